// >>> include/nbs_pkg.sv
// Package for the narrow-memory byte-select bus sequencer.
// Assumes a 32-bit processor bus with four active-low byte-lane enables.
package nbs_pkg;

  // ****************************************
  // Lane patterns and sizes
  // ****************************************
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [3:0] BE_NONE_N = 4'hF;
  localparam logic [3:0] LANES_ALL = 4'hF;
  localparam logic [3:0] LOW_HALF = 4'h3;
  localparam logic [3:0] X11_HIGH_BE_N = 4'h8;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  localparam logic [1:0] LINE_LAST_WORD = 2'h3;
  localparam logic [4:0] FILL_CYCLES_MAX = 5'h10;
  localparam logic [29:0] WORD_STEP = 30'h00000001;

endpackage

// >>> rtl/nbs_lane_step.sv
// Next byte-lane pattern after a cycle that a size indication cut short.
// Assumes the size inputs are already synchronised by the caller.
`timescale 1ns/1ps
module nbs_lane_step
  import nbs_pkg::*;
(
  input wire logic [3:0] be_n_i,
  input wire logic narrow8_size_n_i,
  input wire logic narrow16_size_n_i,
  output logic [3:0] next_be_n_o,
  output logic more_o
);

  logic [3:0] act;

  always_comb
  begin
    act = ~be_n_i;
    next_be_n_o = BE_NONE_N;
    // Low-order lanes go first; the rest is left for the next cycle
    if (!narrow8_size_n_i)
    begin
      next_be_n_o = be_n_i | (act & (~act + 4'h1));
    end
    else if (!narrow16_size_n_i)
    begin
      if ((act & LOW_HALF) != 4'h0)
      begin
        next_be_n_o = be_n_i | LOW_HALF;
      end
    end
    more_o = (next_be_n_o != BE_NONE_N);
  end

endmodule

// >>> rtl/nbs_bus_sequencer.sv
// Bus-cycle sequencer: splits operands and line fills into bus cycles.
// Assumes the ready and size pins come from outside the clock domain.
// Summary of operation
// - Fill runs enough narrow cycles, at most 16
// - Later fill cycles drive correct contiguous lanes
// - Word-spanning operand splits into extra cycles
// - Unaligned split sends highest-order bytes first
// - Dword at x11: upper three, then low byte
// - Forced extra cycles send low-order portion first
`timescale 1ns/1ps
module nbs_bus_sequencer
  import nbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [31:0] req_addr_i,
  input wire logic [1:0] req_size_i,
  input wire logic req_fill_i,
  output logic req_done_o,
  output logic cyc_start_o,
  output logic [29:0] cyc_word_o,
  output logic [3:0] byte_lane_enables_n_o,
  output logic cyc_fill_first_o,
  input wire logic cyc_ready_n_i,
  input wire logic narrow8_size_n_i,
  input wire logic narrow16_size_n_i
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_q1;
  logic [2:0] pin_q2;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_q1 <= 3'h7;
      pin_q2 <= 3'h7;
    end
    else
    begin
      pin_q1 <= {cyc_ready_n_i, narrow8_size_n_i, narrow16_size_n_i};
      pin_q2 <= pin_q1;
    end
  end

  logic rdy;
  logic s8_n;
  logic s16_n;
  assign rdy = ~pin_q2[2];
  assign s8_n = pin_q2[1];
  assign s16_n = pin_q2[0];

  // ****************************************
  // Sequencer state
  // ****************************************
  typedef enum logic [2:0] {
    NBS_IDLE = 3'b001,
    NBS_ISSUE = 3'b010,
    NBS_WAIT = 3'b100
  } nbs_state_t;

  nbs_state_t state;
  nbs_state_t next_state;
  logic [29:0] next_cyc_word;
  logic [3:0] next_be_n;
  logic next_fill_first;
  logic fill;
  logic next_fill;
  logic [1:0] fill_cnt;
  logic [1:0] next_fill_cnt;
  logic pend_low;
  logic next_pend_low;
  logic [29:0] low_word;
  logic [29:0] next_low_word;
  logic [3:0] low_be_n;
  logic [3:0] next_low_be_n;
  logic done;
  logic next_done;

  logic [3:0] step_be_n;
  logic step_more;

  nbs_lane_step u_step (
    .be_n_i(byte_lane_enables_n_o),
    .narrow8_size_n_i(s8_n),
    .narrow16_size_n_i(s16_n),
    .next_be_n_o(step_be_n),
    .more_o(step_more)
  );

  logic take;
  logic [1:0] off;
  logic [2:0] last_byte;
  logic spans;
  logic [3:0] lo_mask;
  logic [3:0] hi_mask;

  always_comb
  begin
    take = req_valid_i && (state == NBS_IDLE);
    off = req_addr_i[1:0];
    last_byte = {1'b0, off} + ((req_size_i == SIZE_DWORD) ? 3'h3 : {1'b0, req_size_i});
    spans = !req_fill_i && last_byte[2];
    lo_mask = LANES_ALL << off;
    hi_mask = LANES_ALL >> (2'h3 - last_byte[1:0]);
  end

  always_comb
  begin
    next_state = state;
    next_cyc_word = cyc_word_o;
    next_be_n = byte_lane_enables_n_o;
    next_fill_first = cyc_fill_first_o;
    next_fill = fill;
    next_fill_cnt = fill_cnt;
    next_pend_low = pend_low;
    next_low_word = low_word;
    next_low_be_n = low_be_n;
    next_done = 1'b0;
    case (state)
      NBS_IDLE:
      begin
        if (take)
        begin
          next_state = NBS_ISSUE;
          next_fill = req_fill_i;
          next_fill_cnt = 2'h0;
          next_fill_first = req_fill_i;
          next_pend_low = spans;
          next_low_word = req_addr_i[31:2];
          next_low_be_n = ~lo_mask;
          if (req_fill_i)
          begin
            // Line starts at its first word with all lanes on
            next_cyc_word = {req_addr_i[31:4], 2'h0};
            next_be_n = BE_ALL_N;
          end
          else if (spans)
          begin
            // Upper word first, lower word held back
            next_cyc_word = req_addr_i[31:2] + WORD_STEP;
            next_be_n = ~hi_mask;
          end
          else
          begin
            next_cyc_word = req_addr_i[31:2];
            next_be_n = ~(lo_mask & hi_mask);
          end
        end
      end
      NBS_ISSUE:
      begin
        next_state = NBS_WAIT;
      end
      NBS_WAIT:
      begin
        if (rdy)
        begin
          next_state = NBS_ISSUE;
          next_fill_first = 1'b0;
          if (step_more)
          begin
            next_be_n = step_be_n;
          end
          else if (pend_low)
          begin
            next_cyc_word = low_word;
            next_be_n = low_be_n;
            next_pend_low = 1'b0;
          end
          else if (fill && (fill_cnt != LINE_LAST_WORD))
          begin
            next_fill_cnt = fill_cnt + 2'h1;
            next_cyc_word = {cyc_word_o[29:2], fill_cnt + 2'h1};
            next_be_n = BE_ALL_N;
          end
          else
          begin
            next_state = NBS_IDLE;
            next_fill = 1'b0;
            next_done = 1'b1;
          end
        end
      end
      default:
      begin
        next_state = NBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= NBS_IDLE;
      cyc_word_o <= 30'h00000000;
      byte_lane_enables_n_o <= BE_NONE_N;
      cyc_fill_first_o <= 1'b0;
      fill <= 1'b0;
      fill_cnt <= 2'h0;
      pend_low <= 1'b0;
      low_word <= 30'h00000000;
      low_be_n <= BE_NONE_N;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cyc_word_o <= next_cyc_word;
      byte_lane_enables_n_o <= next_be_n;
      cyc_fill_first_o <= next_fill_first;
      fill <= next_fill;
      fill_cnt <= next_fill_cnt;
      pend_low <= next_pend_low;
      low_word <= next_low_word;
      low_be_n <= next_low_be_n;
      done <= next_done;
    end
  end

  assign req_ready_o = (state == NBS_IDLE);
  assign cyc_start_o = (state == NBS_ISSUE);
  assign req_done_o = done;

  // ****************************************
  // Checks
  // ****************************************
  logic [4:0] fill_cycles;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fill_cycles <= 5'h00;
    end
    else if (take)
    begin
      fill_cycles <= 5'h00;
    end
    else if (cyc_start_o && fill && (fill_cycles != 5'h1F))
    begin
      fill_cycles <= fill_cycles + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  fill_bound_a: assert property (cyc_start_o && fill |-> fill_cycles < FILL_CYCLES_MAX)
    else $error("line fill issued more than sixteen cycles");
  fill_first_a: assert property (cyc_start_o && cyc_fill_first_o
    |-> byte_lane_enables_n_o == BE_ALL_N)
    else $error("first fill cycle lacks all lanes");
  fill_lanes_a: assert property (cyc_start_o && fill |-> !byte_lane_enables_n_o[3])
    else $error("fill cycle lanes do not reach top lane");
  split_pend_a: assert property (take && spans
    |=> pend_low ##1 (pend_low && state == NBS_WAIT))
    else $error("spanning operand not split");
  high_first_a: assert property (take && spans
    |=> cyc_start_o && cyc_word_o == $past(req_addr_i[31:2]) + WORD_STEP)
    else $error("upper word not sent first");
  x11_dword_a: assert property (take && !req_fill_i && off == 2'h3
    && req_size_i == SIZE_DWORD |=> byte_lane_enables_n_o == X11_HIGH_BE_N)
    else $error("x11 dword first cycle lanes wrong");
  low_first_a: assert property (state == NBS_WAIT && rdy && s8_n && !s16_n
    && byte_lane_enables_n_o == BE_ALL_N |=> cyc_start_o && byte_lane_enables_n_o == LOW_HALF)
    else $error("16-bit split did not move on to upper half");
  no_split_a: assert property (take && !spans |=> !pend_low)
    else $error("aligned operand marked as split");

  fill_run_c: cover property (take && req_fill_i ##[1:200] done);
  split_run_c: cover property (take && spans ##[1:50] done);
  narrow8_c: cover property (state == NBS_WAIT && rdy && !s8_n && step_more);

endmodule

// >>> bench/nbs_mem_model.sv
// Memory-side model: answers each bus cycle and reports its width.
// Assumes one start pulse per bus cycle from the sequencer.
`timescale 1ns/1ps
module nbs_mem_model
  import nbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cyc_start_i,
  input wire logic [1:0] width_i,
  input wire logic [3:0] wait_i,
  output logic ready_n_o,
  output logic narrow8_size_n_o,
  output logic narrow16_size_n_o,
  input wire logic [3:0] be_n_i,
  input wire logic fill_first_i,
  output logic addr_a1_o,
  output logic upper_byte_select_n_o,
  output logic lower_byte_select_n_o,
  output logic [3:0] lane_oe_o
);
  logic [4:0] cnt;
  // Width 0 is a full array, 1 a 16-bit region, 2 an 8-bit region
  assign narrow8_size_n_o = (width_i != 2'h2);
  assign narrow16_size_n_o = (width_i == 2'h0);
  // Byte-select decoder, no storage; a first fill cycle reads as all lanes on
  assign addr_a1_o = be_n_i[0] & be_n_i[1] & !fill_first_i;
  assign upper_byte_select_n_o = be_n_i[1] & be_n_i[3] & !fill_first_i;
  assign lower_byte_select_n_o = be_n_i[0] & (be_n_i[2] | !be_n_i[1]) & !fill_first_i;
  // Steering drives processor lanes only on active lanes, in the data phase
  assign lane_oe_o = ready_n_o ? 4'h0 : ~be_n_i;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt <= 5'h1F;
      ready_n_o <= 1'b1;
    end
    else
    begin
      ready_n_o <= (cnt != 5'h00);
      if (cyc_start_i)
        cnt <= {1'b0, wait_i};
      else if (cnt != 5'h1F)
        cnt <= cnt - 5'h01;
    end
  end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the bus sequencer.
// Assumes the memory model answers every bus cycle.
`timescale 1ns/1ps
module testbench;
  import nbs_pkg::*;
  logic clk;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic [1:0] req_size = 2'h0;
  logic req_fill = 1'b0;
  logic [1:0] width = 2'h0;
  logic [3:0] wait_cyc = 4'h0;
  logic req_ready;
  logic req_done;
  logic cyc_start;
  logic [29:0] word;
  logic [3:0] lanes;
  logic fill_first;
  logic ready_n;
  logic n8;
  logic n16;
  wire [2:0] sels;
  logic [3:0] lane_oe;
  logic [34:0] seen[$];
  logic [3:0] l8[4] = '{4'h0, 4'h1, 4'h3, 4'h7};
  int mismatches = 0;
  int cmp_count = 0;

  nbs_bus_sequencer u_dut (.clk_i(clk), .rst_b_i(rst_b), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_addr_i(req_addr), .req_size_i(req_size),
    .req_fill_i(req_fill), .req_done_o(req_done), .cyc_start_o(cyc_start),
    .cyc_word_o(word), .byte_lane_enables_n_o(lanes), .cyc_fill_first_o(fill_first),
    .cyc_ready_n_i(ready_n), .narrow8_size_n_i(n8), .narrow16_size_n_i(n16));
  nbs_mem_model u_mem (.clk_i(clk), .rst_b_i(rst_b), .cyc_start_i(cyc_start),
    .width_i(width), .wait_i(wait_cyc), .ready_n_o(ready_n),
    .narrow8_size_n_o(n8), .narrow16_size_n_o(n16), .be_n_i(lanes), .fill_first_i(fill_first),
    .addr_a1_o(sels[2]), .upper_byte_select_n_o(sels[1]), .lower_byte_select_n_o(sels[0]),
    .lane_oe_o(lane_oe));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Expected {a1, upper, lower} selects for each lane pattern
  function automatic logic [2:0] sel_exp(input logic f, input logic [3:0] l);
    logic [2:0] r;
    r = 3'h7;
    if (f)
      r = 3'h0;
    else
      case (l)
        4'hE: r = 3'h2;
        4'hD, 4'h9, 4'h1: r = 3'h1;
        4'hC, 4'h8, 4'h0: r = 3'h0;
        4'hB: r = 3'h6;
        4'h7: r = 3'h5;
        4'h3: r = 3'h4;
        default: r = 3'h7;
      endcase
    return r;
  endfunction

  always @(posedge clk)
  begin
    if (cyc_start === 1'b1)
    begin
      seen.push_back({fill_first, word, lanes});
      chk("byte selects", 35'(sel_exp(fill_first, lanes)), 35'(sels));
    end
    if (rst_b === 1'b1)
      chk("lane drive", {31'h0, ready_n ? 4'h0 : ~lanes}, 35'(lane_oe));
  end

  task automatic conclude;
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ex(input int i, input logic f, input logic [29:0] w, input logic [3:0] l);
    chk($sformatf("cycle %0d", i), {f, w, l}, (i < seen.size()) ? seen[i] : 35'hX);
  endtask

  task automatic op(input logic [31:0] a, input logic [1:0] s, input logic f,
    input logic [1:0] m, input int n_cyc);
    int n;
    n = 0;
    seen.delete();
    @(posedge clk);
    width <= m;
    @(posedge clk);
    req_addr <= a;
    req_size <= s;
    req_fill <= f;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk("ready while busy", 35'h0, 35'(req_ready));
    while (req_done !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done", 35'h1, 35'(req_done));
    chk("cycle count", 35'(n_cyc), 35'(seen.size()));
  endtask

  task automatic t_reset;
    repeat (5) @(posedge clk);
    #1;
    chk("reset outputs", {1'b0, 30'h0, 4'hF}, {fill_first, word, lanes});
    chk("reset ready", 35'h4, 35'({req_ready, cyc_start, req_done}));
  endtask

  task automatic t_midreset;
    @(posedge clk);
    width <= 2'h2;
    req_addr <= 32'h500;
    req_fill <= 1'b1;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (7) @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    chk("mid reset outputs", {1'b0, 30'h0, 4'hF}, {fill_first, word, lanes});
    chk("mid reset flags", 35'h4, 35'({req_ready, cyc_start, req_done}));
    @(posedge clk);
    rst_b <= 1'b1;
  endtask

  task automatic t_aligned;
    for (int m = 0; m < 3; m++)
    begin
      op(32'h100, SIZE_DWORD, 1'b0, 2'(m), 1 << m);
      for (int j = 0; j < (1 << m); j++)
        ex(j, 1'b0, 30'h40, l8[j * 4 / (1 << m)]);
    end
  endtask

  task automatic t_x11;
    op(32'h103, SIZE_DWORD, 1'b0, 2'h0, 2);
    ex(0, 1'b0, 30'h41, 4'h8);
    ex(1, 1'b0, 30'h40, 4'h7);
    @(posedge clk);
    wait_cyc <= 4'h3;
    op(32'h103, SIZE_DWORD, 1'b0, 2'h1, 3);
    ex(0, 1'b0, 30'h41, 4'h8);
    ex(1, 1'b0, 30'h41, 4'hB);
    ex(2, 1'b0, 30'h40, 4'h7);
    @(posedge clk);
    wait_cyc <= 4'h0;
  endtask

  task automatic t_words;
    op(32'h103, SIZE_WORD, 1'b0, 2'h1, 2);
    ex(0, 1'b0, 30'h41, 4'hE);
    ex(1, 1'b0, 30'h40, 4'h7);
    op(32'h101, SIZE_WORD, 1'b0, 2'h2, 2);
    ex(0, 1'b0, 30'h40, 4'h9);
    ex(1, 1'b0, 30'h40, 4'hB);
    op(32'h102, SIZE_BYTE, 1'b0, 2'h2, 1);
    ex(0, 1'b0, 30'h40, 4'hB);
  endtask

  task automatic t_fill(input logic [31:0] a, input logic [1:0] m);
    int st;
    st = 1 << m;
    op(a, SIZE_BYTE, 1'b1, m, 4 * st);
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < st; j++)
        ex(k * st + j, k == 0 && j == 0, {a[31:4], 2'(k)}, l8[j * 4 / st]);
  endtask

  initial
  begin
    t_reset;
    @(posedge clk);
    rst_b <= 1'b1;
    t_aligned;
    t_x11;
    t_words;
    t_midreset;
    t_fill(32'h205, 2'h0);
    t_fill(32'h31A, 2'h1);
    t_fill(32'h40F, 2'h2);
    conclude;
  end

  initial
  begin
    #(25 * 5000);
    mismatches++;
    conclude;
  end
endmodule
